// [channel_select_register_defs.svh]
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit aligned register words
// Notes: definitions only
`ifndef CHANNEL_SELECT_REGISTER_DEFS_SVH
`define CHANNEL_SELECT_REGISTER_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_MATCH_A 8'h04
`define OFS_MATCH_B 8'h08
`define OFS_CAPT_A 8'h0C
`define OFS_CAPT_B 8'h10
`define OFS_STATUS 8'h14
`define OFS_ACK 8'h18
`define OFS_CHSEL 8'h1C
`define OFS_EVT_A 8'h20
`define OFS_EVT_B 8'h24
`define OFS_PRESC 8'h28
`define OFS_FORCE 8'h2C
`define OFS_TB1 8'h30
`define OFS_TB2 8'h34
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTRL_W 16
`define CTRL_RST 16'h0000
`define PRESC_RST 8'h01
`define ACK_CLR_BIT 0
`define ACK_ARM_A_BIT 1
`define ACK_ARM_B_BIT 2
`define MODE_COUNT 13
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS 50
`define MIN_TICK_CLKS 2
`define ENGINE_MIN_CLKS 10
`endif

// [channel_select_register_pkg.sv]
// Purpose: types shared by the channel
// Assumes: channel_select_register_defs.svh for numbers
// Notes: enum order is the mode field code
package channel_select_register_pkg;
  typedef enum logic [3:0] {
    single_match_one_edge,
    single_match_two_edge,
    either_match_b_one_edge,
    either_match_b_two_edge,
    either_match_nb_one_edge,
    either_match_nb_two_edge,
    all_matches_needed_one_edge,
    all_matches_needed_two_edge,
    ordered_match_one_edge,
    ordered_match_two_edge,
    cascaded_second_match_one_edge,
    cascaded_second_match_two_edge,
    interlocked_single_match
  } mode_t;
  typedef enum logic [1:0] {act_none, act_high, act_low, act_toggle} pin_act_t;
  typedef struct packed {
    logic tb2_from_angle;
    logic capt_on_input;
    logic xfer_dis;
    logic tb_sel_b;
    logic tb_sel_a;
    pin_act_t act_b;
    pin_act_t act_a;
    logic [2:0] spare2;
    mode_t mode;
  } ctrl_t;
  typedef struct packed {
    logic hit_a;
    logic hit_b;
    logic svc;
  } evt_t;
endpackage : channel_select_register_pkg

// [timer_channel_match_capture.sv]
// Purpose: one timing channel with two match/capture units and two time bases
// Assumes: AXI4-Lite slave, single clock aclk at 20 MHz, sync active-low reset
// Notes: service request is sticky until acknowledged
`timescale 1ns/100ps
`default_nettype none
`include "channel_select_register_defs.svh"
// Functional notes
// - pin forced high, low, toggle, now or on match
// - 24-bit match, counter tick at most every two clocks
// - 24-bit free counters, the first one slowed by a prescaler
// - two comparators allow two-clock pulses
// - input captures use same time bases
// - second base from external input or angle tick
// - each channel holds its own counter pair
// - two units, rearm before a third transition
// - thirteen selectable channel modes
// - legacy single match single transition mode
// - either match modes, both may request service
// - blocking variant: first match blocks second
// - all matches needed before service request
// - ordered variant: second waits for first
// - cascaded: first enables second, second blocks first
// - one edge or two edge service variants
// - match pin transition can be disabled
// - interlocked mode gates transition on match
// - configured transition raises service request
// - thread start or select loads event times
module timer_channel_match_capture #(
  parameter int TB_W = 24,
  parameter int PRESC_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clk_in,
  input wire logic angle_tick,
  input wire logic thread_start,
  input wire logic pin_in,
  output logic pin_out,
  output logic svc_req
);
  import channel_select_register_pkg::*;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] ctrl_bits_reg;
  ctrl_t ctrl;
  logic [TB_W-1:0] match_a_reg, match_b_reg, capt_a_reg, capt_b_reg;
  logic [TB_W-1:0] evt_a_reg, evt_b_reg, tb1_reg, tb2_reg;
  logic [PRESC_W-1:0] presc_reg, div_reg;
  logic hit_a_reg, hit_b_reg, svc_reg, pin_reg, armed_a_reg, armed_b_reg;
  logic [1:0] ev_cnt_reg;
  logic aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic arready_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [2:0] ext_sync_reg, pin_sync_reg;
  logic ext_lvl_reg, pin_lvl_reg, tick1_q_reg, tick2_q_reg;
  assign ctrl = ctrl_t'(ctrl_bits_reg);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a[1:0] == 2'b00) && (a <= `OFS_TB2);
  endfunction
  function automatic logic pin_next(input pin_act_t act, input logic cur);
    case (act)
      act_high: pin_next = 1'b1;
      act_low: pin_next = 1'b0;
      act_toggle: pin_next = ~cur;
      default: pin_next = cur;
    endcase
  endfunction
  // ----------------------------------------
  // bus write side
  // ----------------------------------------
  wire aw_hs = s_axi_awvalid && awready_reg;
  wire w_hs = s_axi_wvalid && wready_reg;
  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire wr_ok = do_write && known_ofs(aw_addr_reg);
  wire wr_ctrl = wr_ok && aw_addr_reg == `OFS_CTRL;
  wire wr_ma = wr_ok && aw_addr_reg == `OFS_MATCH_A;
  wire wr_mb = wr_ok && aw_addr_reg == `OFS_MATCH_B;
  wire wr_ack = wr_ok && aw_addr_reg == `OFS_ACK;
  wire wr_chsel = wr_ok && aw_addr_reg == `OFS_CHSEL;
  wire wr_presc = wr_ok && aw_addr_reg == `OFS_PRESC;
  wire wr_force = wr_ok && aw_addr_reg == `OFS_FORCE;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      aw_addr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata;
      end
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= known_ofs(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // bus read side
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `OFS_CTRL: rd_mux = {16'h0000, ctrl_bits_reg};
      `OFS_MATCH_A: rd_mux = 32'(match_a_reg);
      `OFS_MATCH_B: rd_mux = 32'(match_b_reg);
      `OFS_CAPT_A: rd_mux = 32'(capt_a_reg);
      `OFS_CAPT_B: rd_mux = 32'(capt_b_reg);
      `OFS_STATUS: rd_mux = {24'h00_0000, ev_cnt_reg, armed_b_reg, armed_a_reg,
                             pin_reg, svc_reg, hit_b_reg, hit_a_reg};
      `OFS_EVT_A: rd_mux = 32'(evt_a_reg);
      `OFS_EVT_B: rd_mux = 32'(evt_b_reg);
      `OFS_PRESC: rd_mux = 32'(presc_reg);
      `OFS_TB1: rd_mux = 32'(tb1_reg);
      `OFS_TB2: rd_mux = 32'(tb2_reg);
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= known_ofs(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end
  // ----------------------------------------
  // time bases
  // ----------------------------------------
  wire [PRESC_W-1:0] presc_eff = (presc_reg == '0) ? PRESC_W'(1) : presc_reg;
  wire tick1 = (div_reg >= presc_eff);
  wire ext_agree = ext_sync_reg[1] == ext_sync_reg[2];
  wire ext_rise = ext_agree && ext_sync_reg[1] && !ext_lvl_reg;
  wire tick2 = (ctrl.tb2_from_angle ? angle_tick : ext_rise) && !tick2_q_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_reg <= '0;
      tb1_reg <= '0;
      tb2_reg <= '0;
      ext_sync_reg <= 3'b000;
      ext_lvl_reg <= 1'b0;
      tick1_q_reg <= 1'b0;
      tick2_q_reg <= 1'b0;
    end
    else
    begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_in};
      if (ext_agree)
        ext_lvl_reg <= ext_sync_reg[1];
      div_reg <= tick1 ? '0 : div_reg + PRESC_W'(1);
      if (tick1)
        tb1_reg <= tb1_reg + TB_W'(1);
      if (tick2)
        tb2_reg <= tb2_reg + TB_W'(1);
      tick1_q_reg <= tick1;
      tick2_q_reg <= tick2;
    end
  end
  // ----------------------------------------
  // input pin edge detect
  // ----------------------------------------
  wire pin_agree = pin_sync_reg[1] == pin_sync_reg[2];
  wire pin_edge = pin_agree && (pin_sync_reg[1] != pin_lvl_reg);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_sync_reg <= 3'b000;
      pin_lvl_reg <= 1'b0;
    end
    else
    begin
      pin_sync_reg <= {pin_sync_reg[1:0], pin_in};
      if (pin_agree)
        pin_lvl_reg <= pin_sync_reg[1];
    end
  end
  // ----------------------------------------
  // comparators and mode logic
  // ----------------------------------------
  wire [TB_W-1:0] base_a = ctrl.tb_sel_a ? tb2_reg : tb1_reg;
  wire [TB_W-1:0] base_b = ctrl.tb_sel_b ? tb2_reg : tb1_reg;
  wire fresh_a = ctrl.tb_sel_a ? tick2_q_reg : tick1_q_reg;
  wire fresh_b = ctrl.tb_sel_b ? tick2_q_reg : tick1_q_reg;
  wire raw_a = ctrl.capt_on_input ? pin_edge : (fresh_a && base_a == match_a_reg);
  wire raw_b = ctrl.capt_on_input ? pin_edge : (fresh_b && base_b == match_b_reg);
  wire m_single = ctrl.mode inside {single_match_one_edge, single_match_two_edge};
  wire m_eb = ctrl.mode inside {either_match_b_one_edge, either_match_b_two_edge};
  wire m_enb = ctrl.mode inside {either_match_nb_one_edge, either_match_nb_two_edge};
  wire m_all = ctrl.mode inside {all_matches_needed_one_edge, all_matches_needed_two_edge};
  wire m_ord = ctrl.mode inside {ordered_match_one_edge, ordered_match_two_edge};
  wire m_casc = ctrl.mode inside {cascaded_second_match_one_edge,
                                  cascaded_second_match_two_edge};
  wire m_ilk = ctrl.mode == interlocked_single_match;
  wire two_edge = ctrl.mode inside {single_match_two_edge, either_match_b_two_edge,
                                    either_match_nb_two_edge, all_matches_needed_two_edge,
                                    ordered_match_two_edge,
                                    cascaded_second_match_two_edge};
  // unit A: cascaded mode blocks A once B has matched
  wire ok_a = armed_a_reg && !(m_casc && hit_b_reg);
  wire blk_b = m_eb && (hit_a_reg || ev_a);
  wire need_a = (m_ord || m_casc) && !hit_a_reg;
  wire use_b = !m_single;
  wire ok_b = armed_b_reg && use_b && !blk_b && !need_a;
  wire ev_a = raw_a && ok_a;
  wire ev_b = raw_b && ok_b;
  // interlock: A moves the pin only after B has matched
  wire xfer_a = ev_a && !ctrl.xfer_dis && !(m_ilk && !hit_b_reg);
  wire xfer_b = ev_b && !ctrl.xfer_dis && !m_ilk;
  wire elig_a = ev_a && !m_casc && !(m_all || m_ord) && !(m_ilk && !hit_b_reg);
  wire elig_b = ev_b && !m_ilk && !(m_all || m_ord);
  wire both_done = (m_all || m_ord) && (hit_a_reg || ev_a) && (hit_b_reg || ev_b)
                   && (ev_a || ev_b);
  wire [1:0] n_ev = 2'(ev_a) + 2'(ev_b);
  wire [1:0] cnt_sum = (ev_cnt_reg == 2'd2) ? 2'd2 :
                       ((ev_cnt_reg + n_ev > 2'd2) ? 2'd2 : ev_cnt_reg + n_ev);
  wire elig = elig_a || elig_b || both_done;
  wire svc_set = elig && (!two_edge || cnt_sum == 2'd2);
  wire rearm_a = wr_ack && wdata_reg[`ACK_ARM_A_BIT];
  wire rearm_b = wr_ack && wdata_reg[`ACK_ARM_B_BIT];
  wire svc_clr = wr_ack && wdata_reg[`ACK_CLR_BIT];
  logic pin_mid, pin_new;
  always_comb
  begin
    pin_mid = xfer_a ? pin_next(ctrl.act_a, pin_reg) : pin_reg;
    pin_new = xfer_b ? pin_next(ctrl.act_b, pin_mid) : pin_mid;
    if (wr_force)
      pin_new = pin_next(pin_act_t'(wdata_reg[1:0]), pin_reg);
  end
  // ----------------------------------------
  // channel state
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_bits_reg <= `CTRL_RST;
      match_a_reg <= '0;
      match_b_reg <= '0;
      presc_reg <= `PRESC_RST;
      capt_a_reg <= '0;
      capt_b_reg <= '0;
      evt_a_reg <= '0;
      evt_b_reg <= '0;
      hit_a_reg <= 1'b0;
      hit_b_reg <= 1'b0;
      armed_a_reg <= 1'b0;
      armed_b_reg <= 1'b0;
      ev_cnt_reg <= 2'd0;
      svc_reg <= 1'b0;
      pin_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_bits_reg <= wdata_reg[15:0];
      if (wr_ctrl && wdata_reg[3:0] >= 4'(`MODE_COUNT))
        ctrl_bits_reg[3:0] <= 4'(single_match_one_edge);
      if (wr_ma)
        match_a_reg <= wdata_reg[TB_W-1:0];
      if (wr_mb)
        match_b_reg <= wdata_reg[TB_W-1:0];
      if (wr_presc)
        presc_reg <= wdata_reg[PRESC_W-1:0];
      if (ev_a)
        capt_a_reg <= base_a;
      if (ev_b)
        capt_b_reg <= base_b;
      if (thread_start || wr_chsel)
      begin
        evt_a_reg <= capt_a_reg;
        evt_b_reg <= capt_b_reg;
      end
      // a unit is spent on its event and only an acknowledge rearms it
      armed_a_reg <= rearm_a || (armed_a_reg && !ev_a);
      armed_b_reg <= rearm_b || (armed_b_reg && !ev_b);
      hit_a_reg <= ev_a || (hit_a_reg && !rearm_a);
      hit_b_reg <= ev_b || (hit_b_reg && !rearm_b);
      ev_cnt_reg <= (rearm_a || rearm_b) ? n_ev : cnt_sum;
      // set wins over clear
      svc_reg <= svc_set || (svc_reg && !svc_clr);
      pin_reg <= pin_new;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign pin_out = pin_reg;
  assign svc_req = svc_reg;
endmodule // timer_channel_match_capture
`default_nettype wire

// [engine_model.sv]
// Purpose: service engine seen from the channel
// Assumes: one clock, sync low reset
// Notes: starts a thread no sooner than ten clocks after a request
`timescale 1ns/100ps
`default_nettype none
`include "channel_select_register_defs.svh"
// ----------------------------------------
// engine
// ----------------------------------------
module engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic svc_req,
  output logic thread_start,
  output logic serviced
);
  logic [3:0] wait_cnt;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wait_cnt <= 4'h0;
      thread_start <= 1'b0;
      serviced <= 1'b0;
    end
    else
    begin
      thread_start <= 1'b0;
      if (!svc_req)
      begin
        serviced <= 1'b0;
        wait_cnt <= 4'h0;
      end
      else if (!serviced)
      begin
        if (wait_cnt == 4'(`ENGINE_MIN_CLKS - 1))
        begin
          thread_start <= 1'b1;
          serviced <= 1'b1;
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // engine_model
`default_nettype wire

// [timer_channel_match_capture_monitor.sv]
// Purpose: port checks for the channel
// Assumes: one clock, sync low reset
// Notes: bound at file end
`timescale 1ns/100ps
`default_nettype none
`include "channel_select_register_defs.svh"
// ----------------------------------------
// checks
// ----------------------------------------
module channel_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic svc_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence bad_read;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h34);
  endsequence
  aw_take_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready high after take");
  wr_answer_a: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  rd_refuse_a: assert property (bad_read |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read accepted");
  svc_hold_a: assert property ($fell(svc_req) |-> $rose(s_axi_bvalid))
    else $error("service request lost");
endmodule // channel_monitor
bind timer_channel_match_capture channel_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .svc_req(svc_req));
`default_nettype wire

// [test_timer_channel_match_capture.sv]
// Purpose: self-checking bench for the timer channel
// Assumes: AXI4-Lite master, 20 MHz clock
// Notes: expected answers queued, checked by a watcher process
`timescale 1ns/100ps
`default_nettype none
`include "channel_select_register_defs.svh"
// ----------------------------------------
// bench
// ----------------------------------------
module test_timer_channel_match_capture;
  import channel_select_register_pkg::*;
  typedef struct packed {logic [31:0] m; logic [31:0] d; logic [1:0] r;} exp_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic ext_clk_in = 1'b0;
  logic pin_in = 1'b0, angle_tick = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_out, svc_req, thread_start, serviced;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd_val, r, rx;
  logic [23:0] t, ma, mb;
  exp_t rq[$];
  exp_t e;
  logic [1:0] bq[$];
  int num_errors = 0, checks_done = 0, cycles = 0, seed = 32'h0000_94a7;
  ctrl_t c;
  timer_channel_match_capture u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clk_in(ext_clk_in), .angle_tick(angle_tick), .thread_start(thread_start),
    .pin_in(pin_in), .pin_out(pin_out), .svc_req(svc_req));
  engine_model u_eng (.aclk(aclk), .aresetn(aresetn), .svc_req(svc_req),
    .thread_start(thread_start), .serviced(serviced));
  always #25 aclk = ~aclk;
  always @(posedge aclk)
  begin
    rx = $random(seed);
    ext_clk_in <= rx[0];
    angle_tick <= rx[1];
  end
  task cmp_data(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x)
    begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, x);
    end
  endtask
  task cmp_resp(input logic [1:0] g, input logic [1:0] x);
    cmp_data({30'h0, g}, {30'h0, x});
  endtask
  task cmp_bit(input logic g, input logic x);
    cmp_data({31'h0, g}, {31'h0, x});
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    bq.push_back(x);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d, input logic [1:0] x);
    rq.push_back({m, d, x});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd_val = rdata;
    rready <= 1'b0;
  endtask
  task rdk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d);
    rd(a, m, d, `RESP_OKAY);
  endtask
  task wait_sig(input logic eng);
    for (int n = 0; n < 2000 && (eng ? serviced : svc_req) !== 1'b1; n++)
      @(posedge aclk);
  endtask
  task stamp;
    rdk(`OFS_TB1, 32'h0000_0000, 32'h0000_0000);
    t = rd_val[23:0];
    ma = t + 24'd40;
    mb = t + 24'd80;
  endtask
  always @(posedge aclk)
  begin
    if (rvalid && rready)
    begin
      e = rq.pop_front();
      cmp_data(rdata & e.m, e.d);
      cmp_resp(rresp, e.r);
    end
    if (bvalid && bready) cmp_resp(bresp, bq.pop_front());
  end
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("mismatch %0t timeout", $time);
      test_done;
    end
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdk(`OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdk(`OFS_PRESC, 32'h0000_00FF, 32'h0000_0001);
    rd(8'h38, 32'hFFFF_FFFF, 32'h0000_0000, `RESP_SLVERR);
    wr(8'h02, 32'h0000_0001, `RESP_SLVERR);
    wr(8'h3C, 32'h0000_0001, `RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 14; i++)
    begin
      c = '0;
      c.mode = mode_t'(i);
      wr(`OFS_CTRL, 32'(c), `RESP_OKAY);
      rdk(`OFS_CTRL, 32'h0000_000F, (i < `MODE_COUNT) ? 32'(i) : 32'h0000_0000);
    end
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      wr(`OFS_MATCH_B, r, `RESP_OKAY);
      rdk(`OFS_MATCH_B, 32'hFFFF_FFFF, {8'h00, r[23:0]});
    end
    $display("test fields done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_FORCE, (i < 2) ? 32'(i + 1) : 32'h0000_0003, `RESP_OKAY);
      @(posedge aclk);
      cmp_bit(pin_out, (i == 0 || i == 2));
    end
    $display("test force done");
    stamp();
    c = '0;
    c.mode = single_match_one_edge;
    c.act_a = act_high;
    wr(`OFS_MATCH_A, {8'h00, ma}, `RESP_OKAY);
    wr(`OFS_CTRL, 32'(c), `RESP_OKAY);
    wr(`OFS_ACK, 32'h0000_0007, `RESP_OKAY);
    wait_sig(1'b0);
    cmp_bit(pin_out, 1'b1);
    rdk(`OFS_CAPT_A, 32'h00FF_FFFF, {8'h00, ma});
    wait_sig(1'b1);
    cmp_bit(svc_req, 1'b1);
    rdk(`OFS_EVT_A, 32'h00FF_FFFF, {8'h00, ma});
    wr(`OFS_ACK, 32'h0000_0001, `RESP_OKAY);
    @(posedge aclk);
    cmp_bit(svc_req, 1'b0);
    $display("test single done");
    stamp();
    c.mode = all_matches_needed_one_edge;
    wr(`OFS_MATCH_A, {8'h00, ma}, `RESP_OKAY);
    wr(`OFS_MATCH_B, {8'h00, mb}, `RESP_OKAY);
    wr(`OFS_CTRL, 32'(c), `RESP_OKAY);
    wr(`OFS_ACK, 32'h0000_0007, `RESP_OKAY);
    do
      rdk(`OFS_TB1, 32'h0000_0000, 32'h0000_0000);
    while (rd_val[23:0] - t < 24'd60);
    cmp_bit(svc_req, 1'b0);
    rdk(`OFS_STATUS, 32'h0000_0003, 32'h0000_0001);
    wait_sig(1'b0);
    cmp_bit(svc_req, 1'b1);
    rdk(`OFS_CAPT_B, 32'h00FF_FFFF, {8'h00, mb});
    wr(`OFS_CHSEL, 32'h0000_0000, `RESP_OKAY);
    rdk(`OFS_EVT_B, 32'h00FF_FFFF, {8'h00, mb});
    $display("test both done");
    c = '0;
    c.capt_on_input = 1'b1;
    c.xfer_dis = 1'b1;
    c.act_a = act_toggle;
    wr(`OFS_CTRL, 32'(c), `RESP_OKAY);
    wr(`OFS_ACK, 32'h0000_0007, `RESP_OKAY);
    stamp();
    pin_in <= 1'b1;
    wait_sig(1'b0);
    cmp_bit(svc_req, 1'b1);
    cmp_bit(pin_out, 1'b1);
    rdk(`OFS_CAPT_A, 32'h0000_0000, 32'h0000_0000);
    cmp_bit(rd_val[23:0] - t < 24'd8, 1'b1);
    $display("test capture done");
    stamp();
    c = '0;
    c.mode = either_match_b_one_edge;
    c.act_a = act_low;
    c.act_b = act_high;
    wr(`OFS_MATCH_A, {8'h00, ma}, `RESP_OKAY);
    wr(`OFS_MATCH_B, {8'h00, mb}, `RESP_OKAY);
    wr(`OFS_CTRL, 32'(c), `RESP_OKAY);
    wr(`OFS_ACK, 32'h0000_0007, `RESP_OKAY);
    wait_sig(1'b0);
    cmp_bit(svc_req, 1'b1);
    cmp_bit(pin_out, 1'b0);
    wr(`OFS_ACK, 32'h0000_0001, `RESP_OKAY);
    do
      rdk(`OFS_TB1, 32'h0000_0000, 32'h0000_0000);
    while (rd_val[23:0] - t < 24'd90);
    cmp_bit(svc_req, 1'b0);
    rdk(`OFS_STATUS, 32'h0000_000A, 32'h0000_0000);
    $display("test blocking done");
    test_done;
  end
endmodule // test_timer_channel_match_capture
`default_nettype wire
